// [logic/wit_pkg.sv]
// Constants and types for the watchdog interval timer.
// Contract
// - Reset register comes up as 1f on pin reset only, kept on watchdog reset.
// - Watchdog flag sets on ff-to-00 wrap in watchdog mode only; only 0 written.
// - Watchdog flag clears on zero write only after a read that saw it set.
// - Overflow without reset enable resets counter and control, not the chip.
// - A watchdog-mode overflow drives the active-low overflow output.
// - Internal chip reset starts in the same cycle as the overflow output.
// - Pin reset wins over a coinciding watchdog reset; the flag ends cleared.
// - Overflow output low 133 or 130 cycles; internal reset lasts 519 cycles.
// - Clock control is restored with or without internal reset. The timer resets clock select on every watchdog overflow.
// - Interval-mode overflow sets the interval flag and requests the interrupt.
// - Interval interrupt follows its flag, no transfer trigger; handler clears.
// - Counter and control accept only word writes; byte writes are ignored.
// - Counter and control share one write address; low byte is the data.
// - Reset register is written only by word write at its own address.
// - Clear form clears the flag only; enable form loads bits 6 and 5 only.
// - Byte reads return control, counter and reset register at three addresses.
// - A counter write wins over a coinciding count pulse.
// - While the output is low, writes are ignored and flag reads not seen.
// - A running watchdog (mode 1, enabled) turns standby into sleep; otherwise standby is allowed.
// - Clearing enable stops the counter and holds it at zero.
// - Prescale codes 0 to 7 divide the clock by 2 up to 131072.
// - Mode select 0 is interval mode, 1 is watchdog mode.
package wit_pkg;

    // ****************************************************************
    // Addresses and keys
    // ****************************************************************
    localparam logic [15:0] WIT_ADDR_CTRL_WR = 16'hffa4;
    localparam logic [15:0] WIT_ADDR_RST_WR  = 16'hffa6;
    localparam logic [15:0] WIT_ADDR_CTRL_RD = 16'hffa4;
    localparam logic [15:0] WIT_ADDR_CNT_RD  = 16'hffa5;
    localparam logic [15:0] WIT_ADDR_RST_RD  = 16'hffa7;
    localparam logic [7:0]  WIT_KEY_CTRL     = 8'ha5;
    localparam logic [7:0]  WIT_KEY_CNT      = 8'h5a;
    localparam logic [7:0]  WIT_KEY_CLEAR    = 8'ha5;
    localparam logic [7:0]  WIT_KEY_ENABLE   = 8'h5a;

    // ****************************************************************
    // Field positions and reset values
    // ****************************************************************
    localparam int          WIT_BIT_FLAG     = 7;
    localparam int          WIT_BIT_MODE     = 6;
    localparam int          WIT_BIT_ENABLE   = 5;
    localparam int          WIT_BIT_RSVD     = 5;
    localparam logic [1:0]  WIT_CTRL_ONES    = 2'h3;
    localparam logic [4:0]  WIT_RST_ONES     = 5'h1f;
    localparam logic [7:0]  WIT_RST_INIT     = 8'h1f;
    localparam logic [7:0]  WIT_CNT_MAX      = 8'hff;

    // ****************************************************************
    // Timing
    // ****************************************************************
    localparam logic [7:0]  WIT_OUT_LEN_RST   = 8'h85;
    localparam logic [7:0]  WIT_OUT_LEN_NORST = 8'h82;
    localparam logic [9:0]  WIT_INT_RST_LEN   = 10'h207;
    localparam logic [16:0] WIT_DIV_MASK [8] = '{
        17'h00001, 17'h0003f, 17'h0007f, 17'h001ff,
        17'h007ff, 17'h01fff, 17'h07fff, 17'h1ffff
    };

    // ****************************************************************
    // Bus request carrier
    // ****************************************************************
    typedef struct packed {
        logic        wr;
        logic        rd;
        logic        word;
        logic [15:0] addr;
        logic [15:0] wdata;
    } wit_bus_req_type;

endpackage : wit_pkg

// [logic/wit_timer.sv]
// Watchdog and interval timer with keyed register access.
`timescale 1ns/1ps
module wit_timer (
    input  wire logic                     i_mclk,
    input  wire logic                     i_rst,
    input  wire wit_pkg::wit_bus_req_type i_bus,
    input  wire logic                     i_sleep_exec,
    input  wire logic                     i_standby_select,
    output logic [7:0]                    o_rdata,
    output logic                          o_overflow_output_n,
    output logic                          o_internal_reset,
    output logic                          o_interval_interrupt,
    output logic                          o_enter_standby,
    output logic                          o_enter_sleep
);
    import wit_pkg::*;

    // ****************************************************************
    // State
    // ****************************************************************
    logic [7:0]  count;
    logic        interval_overflow_flag;
    logic        timer_mode_select;
    logic        timer_enable;
    logic [2:0]  clock_prescale_select;
    logic        watchdog_overflow_flag;
    logic        chip_reset_enable;
    logic        rsvd_bit;
    logic [16:0] prescale;
    logic        arm_ovf;
    logic        arm_watchdog_overflow_flag;
    logic [7:0]  out_cnt;
    logic [9:0]  rst_cnt;
    logic        out_low;

    // ****************************************************************
    // Decode
    // ****************************************************************
    logic [7:0] key;
    logic [7:0] low;
    logic       wr_ok;
    logic       wr_ctrl;
    logic       wr_cnt;
    logic       wr_clear;
    logic       wr_enable;
    logic       tick;
    logic       wrap;
    logic       wd_ovf;
    logic       iv_ovf;

    assign key     = i_bus.wdata[15:8];
    assign low     = i_bus.wdata[7:0];
    assign out_low = !o_overflow_output_n;
    // Writes are locked out while the overflow output is low.
    assign wr_ok   = i_bus.wr && i_bus.word && !out_low;
    assign wr_ctrl = wr_ok && i_bus.addr == WIT_ADDR_CTRL_WR
                     && key == WIT_KEY_CTRL;
    assign wr_cnt  = wr_ok && i_bus.addr == WIT_ADDR_CTRL_WR
                     && key == WIT_KEY_CNT;
    assign wr_clear  = wr_ok && i_bus.addr == WIT_ADDR_RST_WR
                       && key == WIT_KEY_CLEAR && low == 8'h00;
    assign wr_enable = wr_ok && i_bus.addr == WIT_ADDR_RST_WR
                       && key == WIT_KEY_ENABLE;

    // ****************************************************************
    // Prescaler and overflow detection
    // ****************************************************************
    // Tick once per divided period; prescaler holds at zero when stopped.
    assign tick = timer_enable &&
        ((prescale & WIT_DIV_MASK[clock_prescale_select])
         == WIT_DIV_MASK[clock_prescale_select]);
    // A counter write in the same cycle suppresses the count pulse.
    assign wrap   = tick && !wr_cnt && count == WIT_CNT_MAX;
    assign wd_ovf = wrap && timer_mode_select;
    assign iv_ovf = wrap && !timer_mode_select;

    always_ff @(posedge i_mclk or posedge i_rst) begin
        if (i_rst) begin
            prescale <= 17'h00000;
        end else if (!timer_enable || wd_ovf) begin
            prescale <= 17'h00000;
        end else begin
            prescale <= prescale + 17'h00001;
        end
    end

    // ****************************************************************
    // Counter
    // ****************************************************************
    always_ff @(posedge i_mclk or posedge i_rst) begin
        if (i_rst) begin
            count <= 8'h00;
        end else if (wd_ovf || !timer_enable) begin
            count <= 8'h00;
        end else if (wr_cnt) begin
            count <= low;
        end else if (tick) begin
            count <= count + 8'h01;
        end
    end

    // ****************************************************************
    // Timer control/status
    // ****************************************************************
    // Any watchdog overflow returns control to its initial state,
    // whether or not the chip itself is reset.
    always_ff @(posedge i_mclk or posedge i_rst) begin
        if (i_rst) begin
            timer_mode_select     <= 1'b0;
            timer_enable          <= 1'b0;
            clock_prescale_select <= 3'h0;
        end else if (wd_ovf) begin
            timer_mode_select     <= 1'b0;
            timer_enable          <= 1'b0;
            clock_prescale_select <= 3'h0;
        end else if (wr_ctrl) begin
            timer_mode_select     <= low[WIT_BIT_MODE];
            timer_enable          <= low[WIT_BIT_ENABLE];
            clock_prescale_select <= low[2:0];
        end
    end

    // The set beats a clear that lands in the same cycle.
    always_ff @(posedge i_mclk or posedge i_rst) begin
        if (i_rst) begin
            interval_overflow_flag <= 1'b0;
        end else if (iv_ovf) begin
            interval_overflow_flag <= 1'b1;
        end else if (wd_ovf) begin
            interval_overflow_flag <= 1'b0;
        end else if (wr_ctrl && !low[WIT_BIT_FLAG] && arm_ovf) begin
            interval_overflow_flag <= 1'b0;
        end
    end

    always_ff @(posedge i_mclk or posedge i_rst) begin
        if (i_rst) begin
            arm_ovf <= 1'b0;
        end else if (wr_ctrl || wd_ovf) begin
            arm_ovf <= 1'b0;
        end else if (i_bus.rd && i_bus.addr == WIT_ADDR_CTRL_RD
                     && interval_overflow_flag) begin
            arm_ovf <= 1'b1;
        end
    end

    // ****************************************************************
    // Reset control/status
    // ****************************************************************
    // Only the pin reset initialises this register; the watchdog's own
    // reset pulse leaves it alone so software can see why it restarted.
    always_ff @(posedge i_mclk or posedge i_rst) begin
        if (i_rst) begin
            chip_reset_enable <= WIT_RST_INIT[6];
            rsvd_bit          <= WIT_RST_INIT[WIT_BIT_RSVD];
        end else if (wr_enable) begin
            chip_reset_enable <= low[6];
            rsvd_bit          <= low[WIT_BIT_RSVD];
        end
    end

    always_ff @(posedge i_mclk or posedge i_rst) begin
        if (i_rst) begin
            watchdog_overflow_flag <= WIT_RST_INIT[7];
        end else if (wd_ovf) begin
            watchdog_overflow_flag <= 1'b1;
        end else if (wr_clear && arm_watchdog_overflow_flag) begin
            watchdog_overflow_flag <= 1'b0;
        end
    end

    // A read during the low phase is not recognised for the clear.
    always_ff @(posedge i_mclk or posedge i_rst) begin
        if (i_rst) begin
            arm_watchdog_overflow_flag <= 1'b0;
        end else if (wr_clear || wd_ovf) begin
            arm_watchdog_overflow_flag <= 1'b0;
        end else if (i_bus.rd && i_bus.addr == WIT_ADDR_RST_RD
                     && watchdog_overflow_flag && !out_low) begin
            arm_watchdog_overflow_flag <= 1'b1;
        end
    end

    // ****************************************************************
    // Overflow output and internal reset
    // ****************************************************************
    always_ff @(posedge i_mclk or posedge i_rst) begin
        if (i_rst) begin
            o_overflow_output_n <= 1'b1;
            out_cnt             <= 8'h00;
        end else if (wd_ovf) begin
            o_overflow_output_n <= 1'b0;
            out_cnt <= (chip_reset_enable ? WIT_OUT_LEN_RST
                        : WIT_OUT_LEN_NORST) - 8'h01;
        end else if (out_low) begin
            if (out_cnt == 8'h00) begin
                o_overflow_output_n <= 1'b1;
            end else begin
                out_cnt <= out_cnt - 8'h01;
            end
        end
    end

    // The chip-level reset does not touch clock control; the overflow itself returns it to default.
    always_ff @(posedge i_mclk or posedge i_rst) begin
        if (i_rst) begin
            o_internal_reset <= 1'b0;
            rst_cnt          <= 10'h000;
        end else if (wd_ovf && chip_reset_enable) begin
            o_internal_reset <= 1'b1;
            rst_cnt          <= WIT_INT_RST_LEN - 10'h001;
        end else if (o_internal_reset) begin
            if (rst_cnt == 10'h000) begin
                o_internal_reset <= 1'b0;
            end else begin
                rst_cnt <= rst_cnt - 10'h001;
            end
        end
    end

    // ****************************************************************
    // Read data, interrupt and standby steering
    // ****************************************************************
    always_ff @(posedge i_mclk or posedge i_rst) begin
        if (i_rst) begin
            o_rdata <= 8'h00;
        end else if (i_bus.rd) begin
            unique case (i_bus.addr)
                WIT_ADDR_CTRL_RD: o_rdata <= {interval_overflow_flag,
                    timer_mode_select, timer_enable, WIT_CTRL_ONES,
                    clock_prescale_select};
                WIT_ADDR_CNT_RD:  o_rdata <= count;
                WIT_ADDR_RST_RD:  o_rdata <= {watchdog_overflow_flag,
                    chip_reset_enable, rsvd_bit, WIT_RST_ONES};
                default:          o_rdata <= 8'h00;
            endcase
        end
    end

    // No transfer-controller request exists; the flag is the request.
    assign o_interval_interrupt = interval_overflow_flag;

    logic wd_running;
    assign wd_running      = timer_enable && timer_mode_select;
    assign o_enter_standby = i_sleep_exec && i_standby_select
                             && !wd_running;
    assign o_enter_sleep   = i_sleep_exec && !o_enter_standby;

    // ****************************************************************
    // Assertions
    // ****************************************************************
    default clocking cb @(posedge i_mclk); endclocking
    default disable iff (i_rst);

    logic [9:0] low_len;
    logic [9:0] irst_len;
    logic       chip_reset_enable_seen;
    always_ff @(posedge i_mclk or posedge i_rst) begin
        if (i_rst) begin
            low_len   <= 10'h000;
            irst_len  <= 10'h000;
            chip_reset_enable_seen <= 1'b0;
        end else begin
            low_len  <= out_low ? low_len + 10'h001 : 10'h000;
            irst_len <= o_internal_reset ? irst_len + 10'h001 : 10'h000;
            if (wd_ovf) begin
                chip_reset_enable_seen <= chip_reset_enable;
            end
        end
    end

    a_out_low_len: assert property (
        $rose(o_overflow_output_n) |->
        low_len == (chip_reset_enable_seen ? 10'h085 : 10'h082))
        else $error("overflow output low length wrong");
    a_int_rst_len: assert property (
        $fell(o_internal_reset) |-> irst_len == 10'h207)
        else $error("internal reset length wrong");
    a_rst_with_out: assert property (
        wd_ovf && chip_reset_enable |=>
        o_internal_reset && !o_overflow_output_n)
        else $error("internal reset not aligned with output");
    a_no_rst_disabled: assert property (
        wd_ovf && !chip_reset_enable |=>
        !o_internal_reset && !timer_enable && count == 8'h00)
        else $error("overflow without enable misbehaved");
    a_watchdog_overflow_flag_cause: assert property (
        $rose(watchdog_overflow_flag) |-> $past(wd_ovf))
        else $error("watchdog flag set without watchdog overflow");
    a_watchdog_overflow_flag_clear_arm: assert property (
        $fell(watchdog_overflow_flag) |->
        $past(wr_clear) && $past(arm_watchdog_overflow_flag))
        else $error("watchdog flag cleared without read");
    a_iv_irq: assert property (
        iv_ovf |=> interval_overflow_flag && o_interval_interrupt)
        else $error("interval overflow did not request interrupt");
    // An overflow in the same cycle legally clears the enable.
    a_byte_wr_ignore: assert property (
        i_bus.wr && !i_bus.word && !wd_ovf |=>
        $stable(timer_enable) && $stable(chip_reset_enable))
        else $error("byte write changed a register");
    a_locked_wr: assert property (
        out_low && i_bus.wr |=>
        $stable(chip_reset_enable) && $stable(clock_prescale_select))
        else $error("write accepted while output low");
    a_write_wins: assert property (
        wr_cnt && timer_enable && !wd_ovf |=> count == $past(low))
        else $error("count write lost to increment");
    a_stop_zero: assert property (
        $past(!timer_enable) && !timer_enable |-> count == 8'h00)
        else $error("stopped counter not zero");

    c_wd_reset: cover property (wd_ovf && chip_reset_enable
        ##1 o_internal_reset [*3]);
    c_wd_noreset: cover property (wd_ovf && !chip_reset_enable);
    c_interval: cover property (iv_ovf ##1 o_interval_interrupt);
    c_flag_clear: cover property (arm_watchdog_overflow_flag ##[1:20] wr_clear);

endmodule : wit_timer

// [sim/wit_cpu_model.sv]
// CPU-side model of the internal bus that reaches the timer registers.
`timescale 1ns/1ps
module wit_cpu_model (
    input  wire logic                     i_mclk,
    input  wire logic [7:0]               i_rdata,
    output wit_pkg::wit_bus_req_type      o_bus
);
    import wit_pkg::*;

    initial o_bus = '0;

    // A released bus shows no stale value, so address and data flip.
    task automatic idle();
        o_bus.wr    = 1'b0;
        o_bus.rd    = 1'b0;
        o_bus.addr  = ~o_bus.addr;
        o_bus.wdata = ~o_bus.wdata;
    endtask : idle

    // Upper byte carries the key, lower byte the data.
    task automatic write(input logic [15:0] addr, input logic [7:0] key,
                         input logic [7:0] data, input logic word);
        @(posedge i_mclk);
        #1;
        o_bus.wr    = 1'b1;
        o_bus.word  = word;
        o_bus.addr  = addr;
        o_bus.wdata = {key, data};
        @(posedge i_mclk);
        #1;
        idle();
    endtask : write

    // A read of a set flag arms the later clearing write.
    task automatic read(input logic [15:0] addr, output logic [7:0] data);
        @(posedge i_mclk);
        #1;
        o_bus.rd   = 1'b1;
        o_bus.addr = addr;
        @(posedge i_mclk);
        #1;
        data = i_rdata;
        idle();
    endtask : read
endmodule : wit_cpu_model

// [sim/watchdog_interval_timer_tb.sv]
// Self-checking bench for the watchdog interval timer.
`timescale 1ns/1ps
module watchdog_interval_timer_tb;
    import wit_pkg::*;

    typedef struct {
        logic        wr;
        logic        word;
        logic [15:0] waddr;
        logic [15:0] wdata;
        logic [15:0] raddr;
        logic [7:0]  exp;
    } wit_row_type;

    logic            i_mclk = 1'b0;
    logic            i_rst  = 1'b1;
    wit_bus_req_type bus;
    logic            sleep  = 1'b0;
    logic            sby    = 1'b0;
    logic [7:0]      rdata;
    logic [7:0]      rd;
    logic            ovf_n;
    logic            irst;
    logic            irq;
    logic            e_stby;
    logic            e_sleep;
    logic [15:0]     low_cnt = '0;
    logic [15:0]     low_len = '0;
    logic [15:0]     rst_cnt = '0;
    logic [15:0]     rst_len = '0;
    logic            irst_fall = 1'b0;
    int              err_total = 0;
    int              checked = 0;
    wit_row_type     rows [8] = '{
        '{1, 0, 16'hffa4, 16'ha527, 16'hffa4, 8'h18},
        '{1, 1, 16'hffa4, 16'h3327, 16'hffa4, 8'h18},
        '{1, 1, 16'hffa4, 16'ha507, 16'hffa4, 8'h1f},
        '{1, 1, 16'hffa4, 16'h5a10, 16'hffa5, 8'h00},
        '{1, 1, 16'hffa6, 16'h5a60, 16'hffa7, 8'h7f},
        '{1, 0, 16'hffa6, 16'h5a00, 16'hffa7, 8'h7f},
        '{1, 1, 16'hffa6, 16'h5a00, 16'hffa7, 8'h1f},
        '{0, 1, 16'hffa6, 16'h0000, 16'hffa8, 8'h00}
    };

    always #5 i_mclk = ~i_mclk;

    wit_timer u_wit_timer (
        .i_mclk               (i_mclk),
        .i_rst                (i_rst),
        .i_bus                (bus),
        .i_sleep_exec         (sleep),
        .i_standby_select     (sby),
        .o_rdata              (rdata),
        .o_overflow_output_n  (ovf_n),
        .o_internal_reset     (irst),
        .o_interval_interrupt (irq),
        .o_enter_standby      (e_stby),
        .o_enter_sleep        (e_sleep)
    );

    wit_cpu_model u_wit_cpu_model (
        .i_mclk  (i_mclk),
        .i_rdata (rdata),
        .o_bus   (bus)
    );

    // Pulse lengths are measured apart from the bus traffic. The low
    // length follows the running count so it is final as the pin rises.
    always @(posedge i_mclk) begin
        if (ovf_n === 1'b0) begin
            low_cnt <= low_cnt + 16'h0001;
            low_len <= low_cnt + 16'h0001;
            if (low_cnt == 16'h0000) begin
                irst_fall <= irst;
            end
        end else if (low_cnt != 16'h0000) begin
            low_cnt <= '0;
        end
        if (irst === 1'b1) begin
            rst_cnt <= rst_cnt + 16'h0001;
        end else if (rst_cnt != 16'h0000) begin
            rst_len <= rst_cnt;
            rst_cnt <= '0;
        end
    end

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        checked++;
        if (got !== exp) begin
            err_total++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    task automatic wait_lvl(input logic v, input int lim);
        int n;
        n = 0;
        while (ovf_n !== v && n < lim) begin
            @(posedge i_mclk);
            #1;
            n++;
        end
        chk(ovf_n, v);
    endtask : wait_lvl

    task automatic results();
        $display("checked=%0d err_total=%0d", checked, err_total);
        if (err_total == 0 && checked > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : results

    initial begin
        #300000;
        err_total++;
        results();
    end

    initial begin
        repeat (16) @(posedge i_mclk);
        #1;
        i_rst = 1'b0;
        // ****************************************************************
        // Keyed writes and byte reads
        // ****************************************************************
        foreach (rows[i]) begin
            if (rows[i].wr) begin
                u_wit_cpu_model.write(rows[i].waddr, rows[i].wdata[15:8],
                    rows[i].wdata[7:0], rows[i].word);
            end
            u_wit_cpu_model.read(rows[i].raddr, rd);
            chk(rd, rows[i].exp);
        end
        // ****************************************************************
        // Interval mode
        // ****************************************************************
        u_wit_cpu_model.write(16'hffa4, 8'ha5, 8'h00, 1'b1);
        u_wit_cpu_model.write(16'hffa4, 8'ha5, 8'h20, 1'b1);
        u_wit_cpu_model.write(16'hffa4, 8'h5a, 8'hfe, 1'b1);
        repeat (8) @(posedge i_mclk);
        #1;
        u_wit_cpu_model.read(16'hffa4, rd);
        chk(rd, 8'hb8);
        chk(irq, 1'b1);
        sleep = 1'b1;
        sby = 1'b1;
        #1;
        chk({e_stby, e_sleep}, 2'h2);
        sleep = 1'b0;
        u_wit_cpu_model.write(16'hffa4, 8'ha5, 8'h20, 1'b1);
        chk(irq, 1'b0);
        u_wit_cpu_model.write(16'hffa4, 8'ha5, 8'h00, 1'b1);
        u_wit_cpu_model.write(16'hffa4, 8'ha5, 8'h21, 1'b1);
        repeat (286) @(posedge i_mclk);
        u_wit_cpu_model.read(16'hffa5, rd);
        chk(rd, 8'h04);
        // ****************************************************************
        // Watchdog mode, chip reset disabled
        // ****************************************************************
        u_wit_cpu_model.write(16'hffa4, 8'ha5, 8'h00, 1'b1);
        u_wit_cpu_model.write(16'hffa4, 8'ha5, 8'h60, 1'b1);
        sleep = 1'b1;
        #1;
        chk({e_stby, e_sleep}, 2'h1);
        sleep = 1'b0;
        u_wit_cpu_model.write(16'hffa4, 8'h5a, 8'hf0, 1'b1);
        wait_lvl(1'b0, 2000);
        u_wit_cpu_model.write(16'hffa6, 8'h5a, 8'h40, 1'b1);
        u_wit_cpu_model.read(16'hffa7, rd);
        wait_lvl(1'b1, 200);
        chk(low_len, 16'h0082);
        chk(irst_fall, 1'b0);
        u_wit_cpu_model.write(16'hffa6, 8'ha5, 8'h00, 1'b1);
        u_wit_cpu_model.read(16'hffa7, rd);
        chk(rd, 8'h9f);
        u_wit_cpu_model.read(16'hffa4, rd);
        chk(rd, 8'h18);
        u_wit_cpu_model.read(16'hffa5, rd);
        chk(rd, 8'h00);
        u_wit_cpu_model.write(16'hffa6, 8'ha5, 8'h00, 1'b1);
        u_wit_cpu_model.read(16'hffa7, rd);
        chk(rd, 8'h1f);
        // ****************************************************************
        // Watchdog mode, chip reset enabled
        // ****************************************************************
        u_wit_cpu_model.write(16'hffa6, 8'h5a, 8'h40, 1'b1);
        u_wit_cpu_model.write(16'hffa4, 8'ha5, 8'h60, 1'b1);
        u_wit_cpu_model.write(16'hffa4, 8'h5a, 8'hf0, 1'b1);
        wait_lvl(1'b0, 2000);
        wait_lvl(1'b1, 200);
        chk(irst_fall, 1'b1);
        chk(low_len, 16'h0085);
        repeat (400) @(posedge i_mclk);
        #1;
        chk(rst_len, 16'h0207);
        u_wit_cpu_model.read(16'hffa7, rd);
        chk(rd, 8'hdf);
        // ****************************************************************
        // Pin reset
        // ****************************************************************
        @(posedge i_mclk);
        #1;
        i_rst = 1'b1;
        repeat (3) @(posedge i_mclk);
        #1;
        chk({ovf_n, irst, irq}, 3'h4);
        i_rst = 1'b0;
        u_wit_cpu_model.read(16'hffa7, rd);
        chk(rd, 8'h1f);
        u_wit_cpu_model.read(16'hffa4, rd);
        chk(rd, 8'h18);
        u_wit_cpu_model.read(16'hffa5, rd);
        chk(rd, 8'h00);
        results();
    end
endmodule : watchdog_interval_timer_tb
